//--- hdl/dss_pkg.sv
/*
  Constants for the deflection soft-start and protection sequencer: register map,
  field positions, reset values and timing counts.
  Assumes a 32-bit APB slave clocked at 250 MHz.
*/
package dss_pkg;
  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] DSS_CTRL_ADDR = 8'h00;
  localparam logic [7:0] DSS_PHASE_ADDR = 8'h04;
  localparam logic [7:0] DSS_ASYM_ADDR = 8'h08;
  localparam logic [7:0] DSS_STATUS_ADDR = 8'h0C;
  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  localparam int DSS_ENABLE_BIT = 0;
  localparam int DSS_ASYM_CONN_BIT = 1;
  localparam int DSS_MOIRE_DIS_BIT = 2;
  localparam int DSS_AGC_DIS_BIT = 3;
  localparam int DSS_MOIRE_LSB = 8;
  localparam logic [3:0] DSS_CTRL_RESET = 4'h2;
  localparam logic [7:0] DSS_MOIRE_RESET = 8'h00;
  localparam logic [7:0] DSS_PHASE_RESET = 8'h80;
  localparam logic [7:0] DSS_ASYM_RESET = 8'h80;
  // ----------------------------------------------------------------------
  // ramp and timing
  // ----------------------------------------------------------------------
  localparam int DSS_RAMP_W = 10;
  localparam logic [9:0] DSS_RAMP_LINE_FULL = 10'h100;
  localparam logic [9:0] DSS_RAMP_SUPPLY_FULL = 10'h200;
  localparam logic [9:0] DSS_RAMP_NORMAL = 10'h300;
  localparam int DSS_CLK_MHZ = 250;
  localparam int DSS_OV_NS = 2000;
  localparam int DSS_OV_CYC = (DSS_OV_NS * DSS_CLK_MHZ + 999) / 1000;
  localparam int DSS_LOCK_NS = 4000;
  localparam int DSS_LOCK_CYC = (DSS_LOCK_NS * DSS_CLK_MHZ + 999) / 1000;
  localparam int DSS_CNT_W = 12;
  localparam int DSS_DUTY_W = 8;

  typedef enum logic [2:0] {
    DSS_OFF, DSS_LINE_RAMP, DSS_SUPPLY_RAMP, DSS_SETTLE, DSS_LOOP_START, DSS_RUN
  } dss_state_e;
endpackage

//--- hdl/dss_sequencer.sv
/*
  Soft-start, standby and over-voltage protection sequencer of a monitor
  deflection controller, with APB register access and phase modulation summing.
  Assumes all pin inputs synchronous to pclk and a line oscillator reference
  period counter supplied by the analog side via line_tick_in.
*/
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
// What this block does
// [RL1] enable bit cleared or ramp node pulled low: both drives stop and float
// [RL2] while inhibited: flyback and frequency loops off, blanking on, unlock floats
// [RL3] on release: line pulses widen with ramp, then supply drive ramps up
// [RL4] ramp reaches normal range: charge stops and both loops are enabled in the same cycle
// [RL5] loops settled: unlock shows vertical blanking, continuous blanking removed
// [RL6] soft start begins only while supply-sufficient indication is present
// [RL7] over-voltage held past qualifying time clears the enable bit
// [RL8] protection: unlock floats, ramp discharged, drives float, blanking held
// [RL9] restart select low: host writes one to enable bit to restart via soft start
// [RL10] restart select high: protection latched until power-on reset
// [RL11] supply low floats the line drive; its pulses are not gated off
// [RL12] clearing asym connect bit removes asym terms from flyback phase only
// [RL13] moire: line/2 modulation scaled by amplitude, polarity flips at half vertical rate
// [RL14] phase offset register sets sync to ramp phase linearly, frequency independent
// [RL15] amplitude-loop disable bit turns off vertical amplitude regulation
// [RL16] sync loop compares sync midpoint with fixed ramp point, fixed gain
// [RL17] flyback loop compares flyback with ramp, shifts line drive phase
// [RL18] continuous blanking also while unlocked searching, no flyback, or protection
// [RL19] over-voltage qualifying time is a persistence counter reset when input drops
// [RL20] ramp is a rising digital level compared with per-stage thresholds
module dss_sequencer
  import dss_pkg::*;
#(
  parameter int OV_CYC = DSS_OV_CYC,
  parameter int LOCK_CYC = DSS_LOCK_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ramp_node_pulled_low_in,
  input wire logic supply_ok_in,
  input wire logic overvoltage_sense_in,
  input wire logic restart_select_in,
  input wire logic flyback_pulse_in,
  input wire logic line_tick_in,
  input wire logic vert_half_tick_in,
  input wire logic vert_blank_in,
  input wire logic sync_unlocked_in,
  input wire logic sync_mid_early_in,
  input wire logic flyback_late_in,
  output logic line_drive_out,
  output logic line_drive_oe,
  output logic supply_drive_out,
  output logic supply_drive_oe,
  output logic clamp_blank_out,
  output logic unlock_indicator_out,
  output logic unlock_indicator_oe,
  output logic ramp_discharge_out,
  output logic ramp_charge_out,
  output logic flyback_loop_en_out,
  output logic freq_loop_en_out,
  output logic amplitude_loop_en_out,
  output logic [7:0] sync_phase_set_out,
  output logic sync_pump_up_out,
  output logic [9:0] flyback_phase_out
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    dss_state_e st;
    logic [3:0] ctrl;
    logic [7:0] moire;
    logic [7:0] phase;
    logic [7:0] paral;
    logic [7:0] pinbal;
    logic prot;
    logic [DSS_RAMP_W-1:0] ramp;
    logic [DSS_CNT_W-1:0] ov_cnt;
    logic [DSS_CNT_W-1:0] lock_cnt;
    logic [DSS_DUTY_W-1:0] pwm;
    logic line_half;
    logic moire_pol;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic ldrv;
    logic ldrv_oe;
    logic sdrv;
    logic sdrv_oe;
    logic blank;
    logic unl;
    logic unl_oe;
    logic disch;
    logic chg;
    logic fl_en;
    logic fq_en;
    logic agc_en;
    logic [7:0] sph;
    logic pump;
    logic [9:0] fph;
  } dss_state_s;

  dss_state_s cur_ff;
  dss_state_s nxt_ff;

  logic access;
  logic wr;
  logic inhibit;
  logic [DSS_DUTY_W-1:0] line_duty;
  logic [DSS_DUTY_W-1:0] sup_duty;
  logic [9:0] asym_sum;
  logic [9:0] moire_term;

  assign access = psel && penable && !cur_ff.ready;
  assign wr = access && pwrite;
  // ramp node low from outside or from cleared enable bit stops the drives
  assign inhibit = ramp_node_pulled_low_in || !cur_ff.ctrl[DSS_ENABLE_BIT]; // [RL1]

  always_comb
  begin
    nxt_ff = cur_ff;
    line_duty = '0;
    sup_duty = '0;
    asym_sum = '0;
    moire_term = '0;
    // --------------------------------------------------------------------
    // apb slave, one wait state
    // --------------------------------------------------------------------
    nxt_ff.ready = access;
    nxt_ff.err = 1'b0;
    if (access)
    begin
      unique case (paddr)
        DSS_CTRL_ADDR:
        begin
          nxt_ff.rdata = {16'h0000, cur_ff.moire, 4'h0, cur_ff.ctrl};
          if (wr)
          begin
            nxt_ff.ctrl = pwdata[3:0];
            nxt_ff.moire = pwdata[DSS_MOIRE_LSB +: 8];
            // latched protection ignores host restart writes
            if (cur_ff.prot && restart_select_in) // [RL10]
              nxt_ff.ctrl[DSS_ENABLE_BIT] = 1'b0;
          end
        end
        DSS_PHASE_ADDR:
        begin
          nxt_ff.rdata = {24'h000000, cur_ff.phase};
          if (wr)
            nxt_ff.phase = pwdata[7:0];
        end
        DSS_ASYM_ADDR:
        begin
          nxt_ff.rdata = {16'h0000, cur_ff.pinbal, cur_ff.paral};
          if (wr)
          begin
            nxt_ff.paral = pwdata[7:0];
            nxt_ff.pinbal = pwdata[15:8];
          end
        end
        DSS_STATUS_ADDR:
          nxt_ff.rdata = {16'h0000, 3'h0, cur_ff.prot, 1'b0, cur_ff.st, cur_ff.ramp[9:2]};
        default:
        begin
          nxt_ff.rdata = 32'h00000000;
          nxt_ff.err = 1'b1;
        end
      endcase
    end
    // --------------------------------------------------------------------
    // over-voltage persistence and protection
    // --------------------------------------------------------------------
    if (!overvoltage_sense_in)
      nxt_ff.ov_cnt = '0; // [RL19]
    else if (cur_ff.ov_cnt != OV_CYC[DSS_CNT_W-1:0])
      nxt_ff.ov_cnt = cur_ff.ov_cnt + 1'b1; // [RL19]
    if (overvoltage_sense_in && cur_ff.ov_cnt == OV_CYC[DSS_CNT_W-1:0])
    begin
      nxt_ff.ctrl[DSS_ENABLE_BIT] = 1'b0; // [RL7]
      nxt_ff.prot = 1'b1;
    end
    else if (wr && paddr == DSS_CTRL_ADDR && pwdata[DSS_ENABLE_BIT] && !restart_select_in)
      nxt_ff.prot = 1'b0; // [RL9]
    // --------------------------------------------------------------------
    // soft-start sequence
    // --------------------------------------------------------------------
    if (inhibit || cur_ff.prot)
    begin
      nxt_ff.st = DSS_OFF; // [RL2]
      nxt_ff.ramp = '0; // [RL8]
      nxt_ff.lock_cnt = '0;
    end
    else
    begin
      unique case (cur_ff.st)
        DSS_OFF:
          if (supply_ok_in)
            nxt_ff.st = DSS_LINE_RAMP; // [RL6]
        DSS_LINE_RAMP, DSS_SUPPLY_RAMP, DSS_SETTLE:
        begin
          nxt_ff.ramp = cur_ff.ramp + 1'b1; // [RL20]
          if (cur_ff.ramp == DSS_RAMP_LINE_FULL)
            nxt_ff.st = DSS_SUPPLY_RAMP; // [RL3]
          else if (cur_ff.ramp == DSS_RAMP_SUPPLY_FULL)
            nxt_ff.st = DSS_SETTLE; // [RL4]
          else if (cur_ff.ramp == DSS_RAMP_NORMAL)
          begin
            nxt_ff.ramp = cur_ff.ramp; // [RL4]
            nxt_ff.st = DSS_LOOP_START;
          end
        end
        DSS_LOOP_START:
          if (cur_ff.lock_cnt == LOCK_CYC[DSS_CNT_W-1:0] && !sync_unlocked_in)
            nxt_ff.st = DSS_RUN; // [RL5]
          else if (cur_ff.lock_cnt != LOCK_CYC[DSS_CNT_W-1:0])
            nxt_ff.lock_cnt = cur_ff.lock_cnt + 1'b1;
        DSS_RUN:
          nxt_ff.st = DSS_RUN;
      endcase
    end
    // --------------------------------------------------------------------
    // drive pulse widths follow the ramp
    // --------------------------------------------------------------------
    if (cur_ff.st == DSS_LINE_RAMP)
      line_duty = cur_ff.ramp[7:0]; // [RL3]
    else if (cur_ff.st != DSS_OFF)
      line_duty = 8'h80;
    if (cur_ff.st == DSS_SUPPLY_RAMP)
      sup_duty = cur_ff.ramp[7:0]; // [RL3]
    else if (cur_ff.st == DSS_SETTLE || cur_ff.st == DSS_LOOP_START || cur_ff.st == DSS_RUN)
      sup_duty = 8'hFF;
    nxt_ff.pwm = cur_ff.pwm + 1'b1;
    nxt_ff.ldrv = cur_ff.pwm < line_duty;
    nxt_ff.sdrv = cur_ff.pwm < sup_duty || sup_duty == 8'hFF;
    nxt_ff.ldrv_oe = cur_ff.st != DSS_OFF && supply_ok_in; // [RL11]
    nxt_ff.sdrv_oe = cur_ff.st != DSS_OFF && cur_ff.st != DSS_LINE_RAMP; // [RL1]
    nxt_ff.disch = inhibit || cur_ff.prot; // [RL8]
    nxt_ff.chg = nxt_ff.st == DSS_LINE_RAMP || nxt_ff.st == DSS_SUPPLY_RAMP
      || nxt_ff.st == DSS_SETTLE; // [RL4]
    nxt_ff.fl_en = nxt_ff.st == DSS_LOOP_START || nxt_ff.st == DSS_RUN; // [RL4]
    nxt_ff.fq_en = nxt_ff.fl_en; // [RL2]
    // --------------------------------------------------------------------
    // blanking and unlock indication
    // --------------------------------------------------------------------
    nxt_ff.blank = cur_ff.st != DSS_RUN || sync_unlocked_in || !flyback_pulse_in
      || cur_ff.prot || !supply_ok_in || vert_blank_in; // [RL18]
    // leaving run floats the indicator at once, together with the loop enables
    nxt_ff.unl_oe = cur_ff.st == DSS_RUN && nxt_ff.st == DSS_RUN && !sync_unlocked_in
      && !cur_ff.prot; // [RL5]
    nxt_ff.unl = vert_blank_in;
    nxt_ff.agc_en = !cur_ff.ctrl[DSS_AGC_DIS_BIT]; // [RL15]
    // --------------------------------------------------------------------
    // phase loops and modulation
    // --------------------------------------------------------------------
    nxt_ff.sph = cur_ff.phase; // [RL14]
    nxt_ff.pump = sync_mid_early_in; // [RL16]
    if (line_tick_in)
      nxt_ff.line_half = !cur_ff.line_half; // [RL13]
    if (vert_half_tick_in)
      nxt_ff.moire_pol = !cur_ff.moire_pol; // [RL13]
    if (cur_ff.ctrl[DSS_ASYM_CONN_BIT])
      asym_sum = {2'b00, cur_ff.paral} + {2'b00, cur_ff.pinbal}; // [RL12]
    if (!cur_ff.ctrl[DSS_MOIRE_DIS_BIT] && (cur_ff.line_half ^ cur_ff.moire_pol))
      moire_term = {2'b00, cur_ff.moire}; // [RL13]
    nxt_ff.fph = asym_sum + moire_term + {9'h000, flyback_late_in}; // [RL17]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_ff <= '0;
      cur_ff.st <= DSS_OFF;
      cur_ff.ctrl <= DSS_CTRL_RESET;
      cur_ff.moire <= DSS_MOIRE_RESET;
      cur_ff.phase <= DSS_PHASE_RESET;
      cur_ff.paral <= DSS_ASYM_RESET;
      cur_ff.pinbal <= DSS_ASYM_RESET;
      cur_ff.blank <= 1'b1;
      cur_ff.disch <= 1'b1;
    end
    else
      cur_ff <= nxt_ff;
  end

  assign prdata = cur_ff.rdata;
  assign pready = cur_ff.ready;
  assign pslverr = cur_ff.err;
  assign line_drive_out = cur_ff.ldrv;
  assign line_drive_oe = cur_ff.ldrv_oe;
  assign supply_drive_out = cur_ff.sdrv;
  assign supply_drive_oe = cur_ff.sdrv_oe;
  assign clamp_blank_out = cur_ff.blank;
  assign unlock_indicator_out = cur_ff.unl;
  assign unlock_indicator_oe = cur_ff.unl_oe;
  assign ramp_discharge_out = cur_ff.disch;
  assign ramp_charge_out = cur_ff.chg;
  assign flyback_loop_en_out = cur_ff.fl_en;
  assign freq_loop_en_out = cur_ff.fq_en;
  assign amplitude_loop_en_out = cur_ff.agc_en;
  assign sync_phase_set_out = cur_ff.sph;
  assign sync_pump_up_out = cur_ff.pump;
  assign flyback_phase_out = cur_ff.fph;
endmodule // dss_sequencer

//--- verification/dss_checker_properties.sv
/*
  Port checker for the deflection soft-start sequencer.
  Assumes the bench sets OV_CYC to 4, so seven cycles of over-voltage always trip it.
*/
`timescale 1ns/1ps
module dss_checker #(
  parameter int OV_CYC = 4
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ramp_node_pulled_low_in,
  input wire logic supply_ok_in,
  input wire logic overvoltage_sense_in,
  input wire logic flyback_pulse_in,
  input wire logic line_drive_oe,
  input wire logic supply_drive_oe,
  input wire logic clamp_blank_out,
  input wire logic unlock_indicator_oe,
  input wire logic ramp_discharge_out,
  input wire logic ramp_charge_out,
  input wire logic flyback_loop_en_out,
  input wire logic freq_loop_en_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_inhibit;
    ramp_node_pulled_low_in [*2];
  endsequence
  sequence s_ov_held;
    overvoltage_sense_in [*7];
  endsequence
  a_inhibit_floats: assert property (
    s_inhibit |=> !line_drive_oe && !supply_drive_oe) else $error("drives not floated");
  a_inhibit_blanks: assert property (
    s_inhibit |=> clamp_blank_out && !unlock_indicator_oe && !flyback_loop_en_out
      && !freq_loop_en_out) else $error("inhibit outputs wrong");
  a_loops_after_charge: assert property (
    $rose(flyback_loop_en_out) |-> !ramp_charge_out) else $error("loop on while charging");
  a_unlock_after_loops: assert property (
    $rose(unlock_indicator_oe) |-> flyback_loop_en_out && freq_loop_en_out)
    else $error("unlock driven before loops");
  a_start_needs_supply: assert property (
    $rose(ramp_charge_out) |-> $past(supply_ok_in) || $past(supply_ok_in, 2))
    else $error("soft start without supply");
  a_low_supply_line: assert property (
    !supply_ok_in [*2] |=> !line_drive_oe) else $error("line drive on at low supply");
  a_ov_protects: assert property (
    s_ov_held |=> !line_drive_oe && !supply_drive_oe && !unlock_indicator_oe
      && clamp_blank_out && ramp_discharge_out) else $error("protection outputs wrong");
  a_no_flyback_blank: assert property (
    !flyback_pulse_in [*2] |=> clamp_blank_out) else $error("no blanking without flyback");
  a_apb_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("apb answer late");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("pready longer than one cycle");
  a_err_with_ready: assert property (
    pslverr |-> pready) else $error("pslverr without pready");
endmodule // dss_checker

bind dss_sequencer dss_checker #(.OV_CYC(OV_CYC)) u_chk (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .ramp_node_pulled_low_in, .supply_ok_in,
  .overvoltage_sense_in, .flyback_pulse_in, .line_drive_oe, .supply_drive_oe,
  .clamp_blank_out, .unlock_indicator_oe, .ramp_discharge_out, .ramp_charge_out,
  .flyback_loop_en_out, .freq_loop_en_out);

//--- verification/dss_far_side.sv
/*
  Far-side model: line oscillator ticks, vertical timing, flyback and sync detectors.
  Assumes one pclk domain; flyback presence is steered by the bench.
*/
`timescale 1ns/1ps
module dss_far_side(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flyback_on,
  output logic line_tick_in,
  output logic vert_half_tick_in,
  output logic vert_blank_in,
  output logic flyback_pulse_in,
  output logic sync_unlocked_in,
  output logic sync_mid_early_in,
  output logic flyback_late_in
);
  logic [7:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  assign line_tick_in = (cnt_ff[1:0] == 2'h3);
  assign vert_half_tick_in = (cnt_ff == 8'hFF);
  assign vert_blank_in = (cnt_ff[7:4] == 4'hF);
  assign flyback_pulse_in = flyback_on;
  // short search phase each frame, so lock is sometimes late
  assign sync_unlocked_in = (cnt_ff < 8'h08);
  assign sync_mid_early_in = cnt_ff[2];
  assign flyback_late_in = cnt_ff[3];
endmodule // dss_far_side

//--- verification/test_dss_sequencer.sv
/*
  Self-checking bench for dss_sequencer with an APB master and a register model.
  Assumes the far-side model supplies line and sync timing.
*/
`timescale 1ns/1ps
module test_dss_sequencer;
  import dss_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, flyback_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic ramp_node_pulled_low_in, supply_ok_in, overvoltage_sense_in, restart_select_in;
  logic line_tick_in, vert_half_tick_in, vert_blank_in, flyback_pulse_in, sync_unlocked_in;
  logic sync_mid_early_in, flyback_late_in, line_drive_out, line_drive_oe, supply_drive_out;
  logic supply_drive_oe, clamp_blank_out, unlock_indicator_out, unlock_indicator_oe;
  logic ramp_discharge_out, ramp_charge_out, flyback_loop_en_out, freq_loop_en_out;
  logic amplitude_loop_en_out, sync_pump_up_out;
  logic [7:0] sync_phase_set_out;
  logic [9:0] flyback_phase_out;
  logic [31:0] mdl[4];
  logic [31:0] msk[4] = '{32'hFF0F, 32'hFF, 32'hFFFF, 32'h0};
  int errors, n_tests, seed;
  dss_sequencer #(.OV_CYC(4), .LOCK_CYC(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ramp_node_pulled_low_in, .supply_ok_in,
    .overvoltage_sense_in, .restart_select_in, .flyback_pulse_in, .line_tick_in,
    .vert_half_tick_in, .vert_blank_in, .sync_unlocked_in, .sync_mid_early_in,
    .flyback_late_in, .line_drive_out, .line_drive_oe, .supply_drive_out, .supply_drive_oe,
    .clamp_blank_out, .unlock_indicator_out, .unlock_indicator_oe, .ramp_discharge_out,
    .ramp_charge_out, .flyback_loop_en_out, .freq_loop_en_out, .amplitude_loop_en_out,
    .sync_phase_set_out, .sync_pump_up_out, .flyback_phase_out);
  dss_far_side u_far (.pclk, .presetn, .flyback_on, .line_tick_in, .vert_half_tick_in,
    .vert_blank_in, .flyback_pulse_in, .sync_unlocked_in, .sync_mid_early_in, .flyback_late_in);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    chk(n < 50, 1, "apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    mdl[a[3:2]] = wd & msk[a[3:2]];
  endtask
  task automatic rchk(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, mdl[a[3:2]], "register read");
    chk(err, 0, "read error");
  endtask
  task automatic wait_run(input string name);
    int n;
    n = 0;
    while (unlock_indicator_oe !== 1'b1 && n < 4000)
    begin
      @(posedge pclk);
      n++;
      if (supply_drive_oe === 1'b1)
        chk(line_drive_oe, 1, "supply before line");
    end
    chk(unlock_indicator_oe, 1, "run reached");
    chk(flyback_loop_en_out & ~ramp_charge_out, 1, "loops on");
    $display("test %s done", name);
  endtask
  // running checks: called right after a rising edge, inputs read here are what the dut sampled
  task automatic watch(input logic [9:0] asym, input logic [9:0] moi);
    logic late, vb, me, un;
    int hi, mo;
    hi = 0;
    mo = 0;
    for (int i = 0; i < 256; i++)
    begin
      late = flyback_late_in;
      vb = vert_blank_in;
      me = sync_mid_early_in;
      un = sync_unlocked_in;
      @(posedge pclk);
      chk(sync_pump_up_out, me, "pump");
      chk(unlock_indicator_out, vb, "unlock level");
      chk(clamp_blank_out, vb | un, "blank removed");
      chk(supply_drive_out, 1, "supply full duty");
      hi += line_drive_out;
      if (flyback_phase_out == asym + moi + late)
        mo++;
      else
        chk(flyback_phase_out, asym + late, "flyback phase");
    end
    chk(hi > 0 && hi < 256, 1, "line pulses");
    chk(moi == 0 ? (mo == 256) : (mo > 64 && mo < 192), 1, "moire");
  endtask
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    final_report();
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    seed = 67540;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {ramp_node_pulled_low_in, overvoltage_sense_in, restart_select_in, supply_ok_in} = '0;
    flyback_on = 1'b1;
    mdl = '{32'h2, 32'h80, 32'h8080, 32'h0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
      rchk(8'(i * 4));
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
    d = $random(seed);
    wr(DSS_PHASE_ADDR, d);
    chk(sync_phase_set_out, d[7:0], "phase offset");
    wr(DSS_ASYM_ADDR, $random(seed));
    rchk(DSS_ASYM_ADDR);
    wr(DSS_CTRL_ADDR, 32'hA50B);
    repeat (20) @(posedge pclk);
    chk(ramp_charge_out | line_drive_oe, 0, "start at low supply");
    chk(amplitude_loop_en_out, 0, "amplitude loop off");
    supply_ok_in <= 1'b1;
    wait_run("startup");
    watch(10'(mdl[2][7:0]) + 10'(mdl[2][15:8]), 10'h0A5);
    wr(DSS_CTRL_ADDR, 32'hA505);
    chk(amplitude_loop_en_out, 1, "amplitude loop on");
    watch(10'h000, 10'h000);
    supply_ok_in <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(line_drive_oe, 0, "low supply line");
    supply_ok_in <= 1'b1;
    flyback_on <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(clamp_blank_out, 1, "no flyback blank");
    flyback_on <= 1'b1;
    ramp_node_pulled_low_in <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(line_drive_oe | supply_drive_oe, 0, "inhibit drives");
    chk({clamp_blank_out, unlock_indicator_oe, freq_loop_en_out}, 3'h4, "inhibit");
    ramp_node_pulled_low_in <= 1'b0;
    wait_run("inhibit");
    overvoltage_sense_in <= 1'b1;
    repeat (4) @(posedge pclk);
    overvoltage_sense_in <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({line_drive_oe, ramp_discharge_out}, 2'h2, "short overvoltage");
    for (int k = 0; k < 2; k++)
    begin
      restart_select_in <= k[0];
      overvoltage_sense_in <= 1'b1;
      repeat (10) @(posedge pclk);
      overvoltage_sense_in <= 1'b0;
      chk({line_drive_oe, ramp_discharge_out}, 2'h1, "protection");
      mdl[0][0] = 1'b0;
      rchk(DSS_CTRL_ADDR);
      apb(1'b0, DSS_STATUS_ADDR, 32'h0);
      chk(rd[12], 1, "protection flag");
      wr(DSS_CTRL_ADDR, mdl[0] | 32'h1);
      if (k == 0)
        wait_run("restart");
    end
    mdl[0][0] = 1'b0;
    rchk(DSS_CTRL_ADDR);
    repeat (20) @(posedge pclk);
    chk(line_drive_oe, 0, "latched protection");
    $display("test latched done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    mdl = '{32'h2, 32'h80, 32'h8080, 32'h0};
    rchk(DSS_CTRL_ADDR);
    wr(DSS_CTRL_ADDR, 32'h3);
    wait_run("power on");
    final_report();
  end
endmodule // test_dss_sequencer
